// [rss_reset_source_sequencer.sv]
// reset source sequencer: five reset sources, ready flag, eeprom probe
`timescale 1ns/1ps

module rss_reset_source_sequencer #(
	parameter int unsigned POR_HOLD_CYCLES = rss_pkg::POR_HOLD_CYC,
	parameter int unsigned PHY_RST_CYCLES = rss_pkg::PHY_RST_CYC,
	parameter int unsigned WAKE_SETTLE_CYCLES = rss_pkg::WAKE_SETTLE_CYC
) (
	// clock and power-on reset
	input wire logic mclk,
	input wire logic rst_n,
	// pins from outside the clock domain
	input wire logic hw_reset_pin_n,
	input wire logic [rss_pkg::STRAP_W-1:0] strap_pins,
	// register write strobes from the host bus interface, one-cycle pulses
	input wire logic sw_reset_wr,
	input wire logic sw_reset_wdata,
	input wire logic phy_rst_wr,
	input wire logic phy_rst_wdata,
	input wire logic phy_bcr_rst_wr,
	input wire logic phy_bcr_rst_wdata,
	input wire logic byte_test_wr,
	input wire logic sleep_req,
	// status from on-chip logic
	input wire logic eeprom_probe_done,
	input wire logic phy_link_up,
	// reset lines and sequencing outputs
	output rss_pkg::rss_domain_rst_s domain_rst,
	output rss_pkg::rss_ctl_bits_s ctl_bits,
	output logic ready,
	output logic power_saving,
	output logic mac_addr_reload,
	output logic strap_latch,
	output logic [rss_pkg::STRAP_W-1:0] straps,
	output logic eeprom_probe_start,
	output logic tx_hold
);

	rss_pkg::rss_state_s st_r;
	rss_pkg::rss_state_s st_nxt;

	localparam logic [rss_pkg::CNT_W-1:0] POR_LAST = rss_pkg::CNT_W'(POR_HOLD_CYCLES - 1);
	localparam logic [rss_pkg::CNT_W-1:0] PIN_LAST =
		rss_pkg::CNT_W'(rss_pkg::PIN_DONE_CYC - 1);
	localparam logic [rss_pkg::CNT_W-1:0] SOFT_LAST =
		rss_pkg::CNT_W'(rss_pkg::SOFT_RST_CYC - 1);
	localparam logic [rss_pkg::CNT_W-1:0] WAKE_LAST = rss_pkg::CNT_W'(WAKE_SETTLE_CYCLES - 1);
	localparam logic [rss_pkg::PHY_CNT_W-1:0] PHY_LAST =
		rss_pkg::PHY_CNT_W'(PHY_RST_CYCLES - 1);

	// which circuits each state keeps in reset
	function automatic rss_pkg::rss_domain_rst_s domains_for(
		input rss_pkg::rss_state_e s,
		input logic phy_soft
	);
		rss_pkg::rss_domain_rst_s d;
		d = '0;
		case (s)
			rss_pkg::RSS_POR, rss_pkg::RSS_PIN_HELD, rss_pkg::RSS_PIN_DONE:
			begin
				d = '1;
			end
			rss_pkg::RSS_SOFT:
			begin
				d.host_bus_interface = 1'b1;
				d.mii = 1'b1;
				d.mac = 1'b1;
				d.phy = phy_soft;
			end
			default:
			begin
				d.phy = phy_soft;
			end
		endcase
		return d;
	endfunction

	function automatic logic full_reset(input rss_pkg::rss_state_e s);
		return (s == rss_pkg::RSS_POR) || (s == rss_pkg::RSS_PIN_HELD) ||
			(s == rss_pkg::RSS_PIN_DONE);
	endfunction

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.mac_addr_reload = 1'b0;
		st_nxt.strap_latch = 1'b0;
		st_nxt.eeprom_probe_start = 1'b0;

		// pin synchronisers; a change counts once stages two and three agree
		st_nxt.pin_sync = {st_r.pin_sync[1:0], hw_reset_pin_n};
		if (st_r.pin_sync[1] == st_r.pin_sync[2])
		begin
			st_nxt.pin_lvl = st_r.pin_sync[2];
		end
		st_nxt.strap_s1 = strap_pins;
		st_nxt.strap_s2 = st_r.strap_s1;
		st_nxt.strap_s3 = st_r.strap_s2;
		for (int i = 0; i < rss_pkg::STRAP_W; i++)
		begin
			if (st_r.strap_s2[i] == st_r.strap_s3[i])
			begin
				st_nxt.strap_lvl[i] = st_r.strap_s3[i];
			end
		end

		st_nxt.cnt = st_r.cnt + rss_pkg::CNT_W'(1);

		// eeprom probe completion; a probe start in this cycle wins below
		if (eeprom_probe_done)
		begin
			st_nxt.ctl.eeprom_busy_flag = 1'b0;
		end

		case (st_r.state)
			rss_pkg::RSS_POR:
			begin
				st_nxt.ready = 1'b0;
				if (st_r.cnt == POR_LAST)
				begin
					st_nxt.state = rss_pkg::RSS_RUN;
				end
			end
			rss_pkg::RSS_PIN_HELD:
			begin
				st_nxt.ready = 1'b0;
				st_nxt.cnt = rss_pkg::CNT_RST;
				if (st_r.pin_lvl)
				begin
					st_nxt.state = rss_pkg::RSS_PIN_DONE;
				end
			end
			rss_pkg::RSS_PIN_DONE:
			begin
				if (st_r.cnt == PIN_LAST)
				begin
					st_nxt.state = rss_pkg::RSS_RUN;
				end
			end
			rss_pkg::RSS_SOFT:
			begin
				if (st_r.cnt == SOFT_LAST)
				begin
					st_nxt.state = rss_pkg::RSS_RUN;
					st_nxt.ctl.software_reset_bit = 1'b0;
				end
			end
			rss_pkg::RSS_RUN:
			begin
				st_nxt.cnt = rss_pkg::CNT_RST;
				if (sw_reset_wr && sw_reset_wdata)
				begin
					st_nxt.state = rss_pkg::RSS_SOFT;
					st_nxt.ctl.software_reset_bit = 1'b1;
					st_nxt.ready = 1'b0;
				end
				else if (sleep_req)
				begin
					st_nxt.state = rss_pkg::RSS_SLEEP;
					st_nxt.ready = 1'b0;
					st_nxt.power_saving = 1'b1;
				end
			end
			rss_pkg::RSS_SLEEP:
			begin
				st_nxt.cnt = rss_pkg::CNT_RST;
				// any data value wakes; other writes are not expected here
				if (byte_test_wr)
				begin
					st_nxt.state = rss_pkg::RSS_WAKE;
				end
			end
			rss_pkg::RSS_WAKE:
			begin
				if (st_r.cnt == WAKE_LAST)
				begin
					st_nxt.state = rss_pkg::RSS_RUN;
					st_nxt.ready = 1'b1;
					st_nxt.power_saving = 1'b0;
				end
			end
			default:
			begin
				st_nxt.state = rss_pkg::RSS_POR;
				st_nxt.cnt = rss_pkg::CNT_RST;
			end
		endcase

		// end of a full or software reset: reload, probe, ready
		if ((st_nxt.state == rss_pkg::RSS_RUN) &&
			((st_r.state == rss_pkg::RSS_POR) || (st_r.state == rss_pkg::RSS_PIN_DONE) ||
			(st_r.state == rss_pkg::RSS_SOFT)))
		begin
			st_nxt.ready = 1'b1;
			st_nxt.mac_addr_reload = 1'b1;
			st_nxt.eeprom_probe_start = 1'b1;
			st_nxt.ctl.eeprom_busy_flag = 1'b1;
			if (st_r.state != rss_pkg::RSS_SOFT)
			begin
				st_nxt.strap_latch = 1'b1;
				st_nxt.straps = st_r.strap_lvl;
			end
		end

		// phy-only resets share one timer; a second request restarts it
		st_nxt.phy_cnt = st_r.phy_cnt + rss_pkg::PHY_CNT_W'(1);
		if (st_r.ctl.phy_rst_bit || st_r.ctl.phy_bcr_rst_bit)
		begin
			if (st_r.phy_cnt == PHY_LAST)
			begin
				st_nxt.ctl.phy_rst_bit = 1'b0;
				st_nxt.ctl.phy_bcr_rst_bit = 1'b0;
			end
		end
		else
		begin
			st_nxt.phy_cnt = rss_pkg::PHY_CNT_RST;
		end
		if (phy_rst_wr && phy_rst_wdata)
		begin
			st_nxt.ctl.phy_rst_bit = 1'b1;
			st_nxt.phy_cnt = rss_pkg::PHY_CNT_RST;
		end
		if (phy_bcr_rst_wr && phy_bcr_rst_wdata)
		begin
			st_nxt.ctl.phy_bcr_rst_bit = 1'b1;
			st_nxt.phy_cnt = rss_pkg::PHY_CNT_RST;
		end

		// pin held low overrides everything else but the reload, probe and strap pulses set above
		if (!st_r.pin_lvl)
		begin
			st_nxt.state = rss_pkg::RSS_PIN_HELD;
			st_nxt.cnt = rss_pkg::CNT_RST;
			st_nxt.ready = 1'b0;
			st_nxt.power_saving = 1'b0;
			st_nxt.ctl = '0;
			st_nxt.phy_cnt = rss_pkg::PHY_CNT_RST;
		end
		else if (full_reset(st_r.state))
		begin
			// the whole phy is reset anyway; writes during full reset are dropped
			st_nxt.ctl.phy_rst_bit = 1'b0;
			st_nxt.ctl.phy_bcr_rst_bit = 1'b0;
			st_nxt.ctl.software_reset_bit = 1'b0;
			st_nxt.phy_cnt = rss_pkg::PHY_CNT_RST;
		end

		st_nxt.rst = domains_for(st_nxt.state,
			st_nxt.ctl.phy_rst_bit | st_nxt.ctl.phy_bcr_rst_bit);

		// transmit stays held from any phy reset until the link is up again
		if (st_nxt.rst.phy)
		begin
			st_nxt.link_wait = 1'b1;
		end
		else if (phy_link_up)
		begin
			st_nxt.link_wait = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st_r.state <= rss_pkg::RSS_POR;
			st_r.cnt <= rss_pkg::CNT_RST;
			st_r.phy_cnt <= rss_pkg::PHY_CNT_RST;
			st_r.pin_sync <= 3'h7;
			st_r.pin_lvl <= 1'b1;
			st_r.strap_s1 <= rss_pkg::STRAP_RST;
			st_r.strap_s2 <= rss_pkg::STRAP_RST;
			st_r.strap_s3 <= rss_pkg::STRAP_RST;
			st_r.strap_lvl <= rss_pkg::STRAP_RST;
			st_r.straps <= rss_pkg::STRAP_RST;
			st_r.ctl <= '0;
			st_r.rst <= '1;
			st_r.ready <= 1'b0;
			st_r.power_saving <= 1'b0;
			st_r.mac_addr_reload <= 1'b0;
			st_r.strap_latch <= 1'b0;
			st_r.eeprom_probe_start <= 1'b0;
			st_r.link_wait <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ready is a plain flop output, never gated by bus activity
	assign ready = st_r.ready;
	assign domain_rst = st_r.rst;
	assign ctl_bits = st_r.ctl;
	assign power_saving = st_r.power_saving;
	assign mac_addr_reload = st_r.mac_addr_reload;
	assign strap_latch = st_r.strap_latch;
	assign straps = st_r.straps;
	assign eeprom_probe_start = st_r.eeprom_probe_start;
	assign tx_hold = st_r.link_wait;

endmodule // rss_reset_source_sequencer

// [rss_pkg.sv]
// shared constants and types for the reset source sequencer
package rss_pkg;

	// clock
	localparam int unsigned CLK_MHZ = 50;

	// timing, figures in nanoseconds
	localparam int unsigned POR_HOLD_NS = 22000000;
	localparam int unsigned PIN_DONE_NS = 1000;
	localparam int unsigned SOFT_RST_NS = 2000;
	localparam int unsigned PHY_RST_NS = 100000;
	localparam int unsigned WAKE_MAX_NS = 2000000;
	localparam int unsigned WAKE_SETTLE_NS = 1000;

	// cycle counts, least times rounded up
	localparam int unsigned POR_HOLD_CYC = (POR_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PIN_DONE_CYC = (PIN_DONE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SOFT_RST_CYC = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PHY_RST_CYC = (PHY_RST_NS * CLK_MHZ + 999) / 1000;
	// longest time, rounded down; the settle time must stay below it
	localparam int unsigned WAKE_MAX_CYC = (WAKE_MAX_NS * CLK_MHZ) / 1000;
	localparam int unsigned WAKE_SETTLE_CYC = (WAKE_SETTLE_NS * CLK_MHZ + 999) / 1000;

	// widths
	localparam int unsigned CNT_W = 21;
	localparam int unsigned PHY_CNT_W = 13;
	localparam int unsigned STRAP_W = 8;

	// field positions of the self-clearing bits in their registers
	localparam int unsigned SW_RESET_BIT_POS = 0;
	localparam int unsigned PHY_RST_BIT_POS = 10;
	localparam int unsigned PHY_BCR_RST_BIT_POS = 15;
	localparam int unsigned EEPROM_BUSY_BIT_POS = 31;

	// reset values
	localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 21'h000000;
	localparam logic [PHY_CNT_W-1:0] PHY_CNT_RST = 13'h0000;

	typedef enum logic [2:0] {
		RSS_POR,
		RSS_PIN_HELD,
		RSS_PIN_DONE,
		RSS_SOFT,
		RSS_RUN,
		RSS_SLEEP,
		RSS_WAKE
	} rss_state_e;

	// reset lines to the internal circuits, active high
	typedef struct packed {
		logic pll;
		logic host_bus_interface;
		logic soft_reset_immune;
		logic mii;
		logic mac;
		logic phy;
	} rss_domain_rst_s;

	// self-clearing control bits as software sees them
	typedef struct packed {
		logic software_reset_bit;
		logic phy_rst_bit;
		logic phy_bcr_rst_bit;
		logic eeprom_busy_flag;
	} rss_ctl_bits_s;

	typedef struct packed {
		rss_state_e state;
		logic [CNT_W-1:0] cnt;
		logic [PHY_CNT_W-1:0] phy_cnt;
		logic [2:0] pin_sync;
		logic pin_lvl;
		logic [STRAP_W-1:0] strap_s1;
		logic [STRAP_W-1:0] strap_s2;
		logic [STRAP_W-1:0] strap_s3;
		logic [STRAP_W-1:0] strap_lvl;
		logic [STRAP_W-1:0] straps;
		rss_ctl_bits_s ctl;
		rss_domain_rst_s rst;
		logic ready;
		logic power_saving;
		logic mac_addr_reload;
		logic strap_latch;
		logic eeprom_probe_start;
		logic link_wait;
	} rss_state_s;

endpackage

// [rss_chk.sv]
// port assertions for the reset source sequencer
`timescale 1ns/1ps
module rss_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// strobes and status in
	input wire logic sw_reset_wr,
	input wire logic sw_reset_wdata,
	input wire logic sleep_req,
	input wire logic byte_test_wr,
	input wire logic eeprom_probe_done,
	input wire logic phy_link_up,
	// sequencer outputs
	input rss_pkg::rss_domain_rst_s domain_rst,
	input rss_pkg::rss_ctl_bits_s ctl_bits,
	input wire logic ready,
	input wire logic power_saving,
	input wire logic mac_addr_reload,
	input wire logic strap_latch,
	input wire logic eeprom_probe_start,
	input wire logic tx_hold
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	sequence s_soft_on;
		ctl_bits.software_reset_bit && !ready && domain_rst.mac && domain_rst.mii
			&& domain_rst.host_bus_interface && !domain_rst.pll;
	endsequence
	sequence s_done;
		ready && mac_addr_reload && eeprom_probe_start && ctl_bits.eeprom_busy_flag;
	endsequence
	a_soft_start: assert property (
		sw_reset_wr && sw_reset_wdata && ready && !power_saving |=> s_soft_on)
		else $error("soft reset did not start");
	a_soft_len: assert property (
		$rose(ctl_bits.software_reset_bit) |->
			##99 ctl_bits.software_reset_bit ##1 !ctl_bits.software_reset_bit)
		else $error("soft reset length wrong");
	a_soft_done: assert property (
		$fell(ctl_bits.software_reset_bit) && !domain_rst.pll |-> s_done and !strap_latch)
		else $error("soft reset end wrong");
	a_full_done: assert property (
		$fell(domain_rst.pll) |-> s_done and strap_latch && !domain_rst.phy)
		else $error("full reset end wrong");
	a_ready_safe: assert property (
		ready |-> !domain_rst.pll && !domain_rst.mac)
		else $error("ready during reset");
	a_phy_only: assert property (
		$rose(ctl_bits.phy_rst_bit) |-> domain_rst.phy && tx_hold && !domain_rst.mac
			##9 ctl_bits.phy_rst_bit ##1 !ctl_bits.phy_rst_bit)
		else $error("phy reset wrong");
	a_bcr_only: assert property (
		$rose(ctl_bits.phy_bcr_rst_bit) |-> domain_rst.phy && !domain_rst.mac
			##9 ctl_bits.phy_bcr_rst_bit ##1 !ctl_bits.phy_bcr_rst_bit)
		else $error("phy control reset wrong");
	a_tx_release: assert property (
		tx_hold && phy_link_up && !domain_rst.phy && !domain_rst.pll |=> !tx_hold)
		else $error("transmit hold stuck");
	a_sleep_enter: assert property (
		sleep_req && ready && !sw_reset_wr |=> !ready && power_saving)
		else $error("sleep not entered");
	a_wake_time: assert property (
		byte_test_wr && power_saving |-> ##6 ready && !power_saving)
		else $error("wake too slow");
	a_busy_clear: assert property (
		ctl_bits.eeprom_busy_flag && eeprom_probe_done && !eeprom_probe_start
			|=> !ctl_bits.eeprom_busy_flag)
		else $error("probe busy stuck");
endmodule // rss_chk
bind rss_reset_source_sequencer rss_chk u_rss_chk (.mclk(mclk), .rst_n(rst_n),
	.sw_reset_wr(sw_reset_wr), .sw_reset_wdata(sw_reset_wdata), .sleep_req(sleep_req),
	.byte_test_wr(byte_test_wr), .eeprom_probe_done(eeprom_probe_done),
	.phy_link_up(phy_link_up), .domain_rst(domain_rst), .ctl_bits(ctl_bits),
	.ready(ready), .power_saving(power_saving), .mac_addr_reload(mac_addr_reload),
	.strap_latch(strap_latch), .eeprom_probe_start(eeprom_probe_start), .tx_hold(tx_hold));

// [rss_host_model.sv]
// host and eeprom controller stand-in facing the sequencer
`timescale 1ns/1ps
module rss_host_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// bench requests, one cycle each
	input wire logic [4:0] req,
	// device status
	input wire logic ready,
	input wire logic power_saving,
	input wire logic eeprom_probe_start,
	// strobes to the device
	output logic sw_reset_wr,
	output logic phy_rst_wr,
	output logic phy_bcr_rst_wr,
	output logic byte_test_wr,
	output logic sleep_req,
	output logic eeprom_probe_done
);
	logic [1:0] probe_cnt_r;
	// writes pass only while ready and are dropped otherwise; only the wake write while asleep
	assign sw_reset_wr = req[0] & ready;
	assign phy_rst_wr = req[1] & ready;
	assign phy_bcr_rst_wr = req[2] & ready;
	assign byte_test_wr = req[3] & power_saving;
	assign sleep_req = req[4] & ready;
	// probe answers a few cycles after it starts
	assign eeprom_probe_done = (probe_cnt_r == 2'h1);
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			probe_cnt_r <= 2'h0;
		else if (eeprom_probe_start)
			probe_cnt_r <= 2'h3;
		else if (probe_cnt_r != 2'h0)
			probe_cnt_r <= probe_cnt_r - 2'h1;
	end
endmodule // rss_host_model

// [rss_testbench.sv]
// self-checking bench for the reset source sequencer
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic pin_n = 1'b1;
	logic link = 1'b0;
	logic wdata = 1'b1;
	logic [4:0] req = 5'h00;
	logic [7:0] strap_pins = 8'hA5;
	logic sw_wr, phy_wr, bcr_wr, byte_wr, sleep, probe_done;
	rss_pkg::rss_domain_rst_s domain_rst;
	rss_pkg::rss_ctl_bits_s ctl_bits;
	logic ready, power_saving, mac_addr_reload, strap_latch, probe_start, tx_hold;
	logic [7:0] straps;
	int fails = 0;
	int check_count = 0;
	int n;
	always #10 mclk = ~mclk;
	rss_reset_source_sequencer #(.POR_HOLD_CYCLES(20), .PHY_RST_CYCLES(10),
		.WAKE_SETTLE_CYCLES(5)) u_rss_reset_source_sequencer (.mclk(mclk), .rst_n(rst_n),
		.hw_reset_pin_n(pin_n), .strap_pins(strap_pins), .sw_reset_wr(sw_wr),
		.sw_reset_wdata(wdata), .phy_rst_wr(phy_wr), .phy_rst_wdata(wdata),
		.phy_bcr_rst_wr(bcr_wr), .phy_bcr_rst_wdata(wdata), .byte_test_wr(byte_wr),
		.sleep_req(sleep), .eeprom_probe_done(probe_done), .phy_link_up(link),
		.domain_rst(domain_rst), .ctl_bits(ctl_bits), .ready(ready),
		.power_saving(power_saving), .mac_addr_reload(mac_addr_reload),
		.strap_latch(strap_latch), .straps(straps), .eeprom_probe_start(probe_start),
		.tx_hold(tx_hold));
	rss_host_model u_rss_host_model (.mclk(mclk), .rst_n(rst_n), .req(req), .ready(ready),
		.power_saving(power_saving), .eeprom_probe_start(probe_start), .sw_reset_wr(sw_wr),
		.phy_rst_wr(phy_wr), .phy_bcr_rst_wr(bcr_wr), .byte_test_wr(byte_wr),
		.sleep_req(sleep), .eeprom_probe_done(probe_done));
	task stop_test;
		$display("checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic c, input string m);
		check_count++;
		if (c !== 1'b1)
		begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task pulse(input int k);
		@(posedge mclk);
		req[k] <= 1'b1;
		@(posedge mclk);
		req[k] <= 1'b0;
		#1;
	endtask
	// bounded poll; running out of polls fails the check that follows
	task wait_ready(input int lim);
		n = 0;
		while (ready !== 1'b1 && n < lim)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask
	task t_por;
		wait_ready(60);
		chk(n >= 20 && n <= 24 && domain_rst === '0, "power-on end");
		chk(straps === 8'hA5 && ctl_bits.eeprom_busy_flag === 1'b1, "straps or busy");
		// the probe answers within five cycles and the busy flag must clear
		repeat (5) @(posedge mclk);
		#1;
		chk(ctl_bits.eeprom_busy_flag === 1'b0, "busy stuck");
	endtask
	task t_soft;
		@(posedge mclk);
		wdata <= 1'b0;
		pulse(0);
		pulse(1);
		chk(ready === 1'b1 && ctl_bits[3:2] === 2'h0, "write of 0 acted");
		@(posedge mclk);
		wdata <= 1'b1;
		pulse(0);
		chk(ready === 1'b0 && domain_rst.pll === 1'b0 && domain_rst.phy === 1'b0, "soft reach");
		n = 0;
		while (ctl_bits.software_reset_bit === 1'b1 && n < 200)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk(n == 100 && ready === 1'b1 && mac_addr_reload === 1'b1, "soft length");
		chk(straps === 8'hA5 && ctl_bits.eeprom_busy_flag === 1'b1, "soft straps");
	endtask
	task t_phy;
		for (int k = 1; k <= 2; k++)
		begin
			pulse(k);
			chk(domain_rst.phy === 1'b1 && domain_rst.mac === 1'b0, "phy reach");
			repeat (9) @(posedge mclk);
			#1;
			chk(ctl_bits[3-k] === 1'b1, "phy bit early");
			@(posedge mclk);
			#1;
			chk(ctl_bits[3-k] === 1'b0 && tx_hold === 1'b1, "phy bit or hold");
			@(posedge mclk);
			link <= 1'b1;
			@(posedge mclk);
			#1;
			chk(tx_hold === 1'b0, "hold stuck");
			@(posedge mclk);
			link <= 1'b0;
		end
	endtask
	task t_sleep;
		pulse(4);
		chk(ready === 1'b0 && power_saving === 1'b1, "no sleep");
		repeat (3) @(posedge mclk);
		pulse(3);
		wait_ready(20);
		chk(n == 5 && power_saving === 1'b0, "wake time");
	endtask
	task t_pin;
		@(posedge mclk);
		pin_n <= 1'b0;
		strap_pins <= 8'h5A;
		repeat (8) @(posedge mclk);
		#1;
		chk(ready === 1'b0 && domain_rst === '1, "pin reach");
		@(posedge mclk);
		pin_n <= 1'b1;
		wait_ready(100);
		chk(n >= 50 && n <= 58 && straps === 8'h5A, "pin end");
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t_por();
		@(posedge mclk);
		strap_pins <= 8'h3C;
		t_soft();
		t_phy();
		t_sleep();
		t_pin();
		stop_test();
	end
	initial
	begin
		#100000;
		fails++;
		stop_test();
	end
endmodule // testbench
